// ==== src/lff_formatter.sv ====
`timescale 1ns/100ps
`default_nettype none

module lff_formatter (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic link_up_i,
   input wire logic retry_active_i,
   input wire lff_pkg::lff_ctrl_req_t ctrl_req_i,
   input wire logic [7:0] ack_seq_i,
   input wire logic [7:0] fct_vc_i,
   input wire logic df_req_i,
   input wire logic [7:0] df_vc_i,
   input wire logic [6:0] df_len_i,
   input wire lff_pkg::lff_vcb_word_t df_word_i,
   input wire logic bc_req_i,
   input wire lff_pkg::lff_bcast_t bc_i,
   output lff_pkg::lff_lane_word_t tx_o,
   output lff_pkg::lff_ctrl_req_t ctrl_grant_o,
   output logic df_start_o,
   output logic df_pop_o,
   output logic bc_take_o
);

   typedef enum logic [2:0] {
      DF_IDLE = 3'b001,
      DF_BODY = 3'b010,
      DF_END = 3'b100
   } lff_df_st_t;

   typedef enum logic [3:0] {
      BC_IDLE = 4'b0001,
      BC_D1 = 4'b0010,
      BC_D2 = 4'b0100,
      BC_END = 4'b1000
   } lff_bc_st_t;

   typedef enum logic [3:0] {
      SL_SKIP, SL_INIT, SL_INIT_ACKNOWLEDGE_WORD, SL_RESET_CLEAR_WORD, SL_RESET_ACKNOWLEDGE_WORD, SL_LOS, SL_STBY, SL_LANE_SYNC_WORD,
      SL_BC, SL_ACK, SL_NACK, SL_FCT, SL_DF, SL_IF, SL_IDLE
   } lff_slot_t;

   ////////////////////////////////////////////////////////////////////////////
   // Request qualification and slot choice.

   lff_df_st_t df_st_r;
   lff_bc_st_t bc_st_r;
   lff_slot_t slot;
   lff_pkg::lff_ctrl_req_t req;
   logic df_pend, bc_pend, frame_wait;
   logic if_act_r;
   logic [6:0] if_cnt_r;

   // A request still high in the cycle of its grant was already served.
   assign req = ctrl_req_i & ~ctrl_grant_o;
   assign df_pend = df_req_i & ~df_start_o;
   assign bc_pend = bc_req_i & ~bc_take_o;
   assign frame_wait = df_pend | bc_pend | req.flow_control_token;

   always_comb begin
      slot = SL_IDLE;
      if (!link_up_i) begin
         if (req.skip) begin
            slot = SL_SKIP;
         end else if (req.init) begin
            slot = SL_INIT;
         end else if (req.init_acknowledge_word) begin
            slot = SL_INIT_ACKNOWLEDGE_WORD;
         end else if (req.reset_clear_word) begin
            slot = SL_RESET_CLEAR_WORD;
         end else if (req.reset_acknowledge_word) begin
            slot = SL_RESET_ACKNOWLEDGE_WORD;
         end
      end else if (req.skip) begin
         slot = SL_SKIP;
      end else if (req.reset_clear_word) begin
         slot = SL_RESET_CLEAR_WORD;
      end else if (req.reset_acknowledge_word) begin
         slot = SL_RESET_ACKNOWLEDGE_WORD;
      end else if (req.los) begin
         slot = SL_LOS;
      end else if (req.stby) begin
         slot = SL_STBY;
      end else if (req.lane_sync_word) begin
         slot = SL_LANE_SYNC_WORD;
      end else if (bc_st_r != BC_IDLE || (bc_pend && !retry_active_i)) begin
         slot = SL_BC;
      end else if (req.ack) begin
         slot = SL_ACK;
      end else if (req.nack) begin
         slot = SL_NACK;
      end else if (req.flow_control_token && !retry_active_i) begin
         slot = SL_FCT;
      end else if (df_st_r != DF_IDLE || (df_pend && !retry_active_i)) begin
         slot = SL_DF;
      end else if (!frame_wait && !retry_active_i) begin
         slot = SL_IF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequence, checksums and idle generators.

   logic [7:0] fseq_r;
   logic [7:0] df_seq_r, bc_seq_r;
   logic [15:0] df_crc_r, crc16_in, crc16_out;
   logic [7:0] bc_crc_r, crc8_in, crc8_out;
   logic [2:0] crc16_nb, crc8_nb;
   logic [31:0] seed_state, prbs_next;
   logic [31:0] word_data;
   logic [2:0] bseq_mem_r [256];
   lff_pkg::lff_bcast_t bc_r;
   logic [7:0] df_vc_r;
   logic [6:0] df_len_r, df_cnt_r;
   logic [6:0] df_len_eff;
   lff_pkg::lff_lane_word_t tx_nxt;

   assign crc16_in = (df_st_r == DF_IDLE) ? lff_pkg::CRC16_INIT : df_crc_r;
   assign crc16_nb = (df_st_r == DF_END) ? 3'h2 : 3'h4;
   assign crc8_in = (bc_st_r == BC_IDLE) ? lff_pkg::CRC8_INIT : bc_crc_r;
   assign crc8_nb = (bc_st_r == BC_END) ? 3'h3 : 3'h4;

   lff_crc #(.W(16), .POLY(lff_pkg::CRC16_POLY)) u_crc16 (
      .crc_i(crc16_in),
      .data_i(word_data),
      .nbytes_i(crc16_nb),
      .crc_o(crc16_out)
   );

   lff_crc #(.W(8), .POLY(lff_pkg::CRC8_POLY)) u_crc8 (
      .crc_i(crc8_in),
      .data_i(word_data),
      .nbytes_i(crc8_nb),
      .crc_o(crc8_out)
   );

   // The seed source free-runs so that successive idle frames differ.
   lff_lfsr #(.TAPS(lff_pkg::PRBS_TAPS), .RESET_VAL(lff_pkg::SEED_RESET)) u_seed (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .load_i(1'b0),
      .seed_i(32'h00000000),
      .step_i(1'b1),
      .state_o(seed_state),
      .next_o()
   );

   lff_lfsr #(.TAPS(lff_pkg::PRBS_TAPS), .RESET_VAL(lff_pkg::PRBS_RESET)) u_prbs (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .load_i(slot == SL_IF && if_act_r && if_cnt_r == 7'h00),
      .seed_i(seed_state),
      .step_i(slot == SL_IF && if_act_r && if_cnt_r != 7'h00),
      .state_o(),
      .next_o(prbs_next)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Word assembly.

   assign df_len_eff = (df_len_i == 7'h00) ? 7'h01 :
                       (df_len_i > lff_pkg::DF_MAX_WORDS) ? lff_pkg::DF_MAX_WORDS : df_len_i;

   always_comb begin
      lff_pkg::lff_lane_word_t w;
      w = lff_pkg::lff_ctrl_word(lff_pkg::CW_IDLE, lff_pkg::SYM_D0_0);
      case (slot)
         SL_SKIP: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_SKIP, lff_pkg::SYM_D0_0);
         SL_INIT: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_INIT, lff_pkg::SYM_D0_0);
         SL_INIT_ACKNOWLEDGE_WORD: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_INIT_ACK, lff_pkg::SYM_D0_0);
         SL_RESET_CLEAR_WORD: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_RESET_CLR, lff_pkg::SYM_D0_0);
         SL_RESET_ACKNOWLEDGE_WORD: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_RESET_ACK, lff_pkg::SYM_D0_0);
         SL_LOS: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_LOST_SIG, lff_pkg::SYM_D0_0);
         SL_STBY: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_STANDBY, lff_pkg::SYM_D0_0);
         SL_LANE_SYNC_WORD: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_LANE_SYNC, lff_pkg::SYM_D0_0);
         SL_ACK: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_ACK, ack_seq_i);
         SL_NACK: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_NACK, ack_seq_i);
         SL_FCT: begin
            w.k = 4'h1;
            w.data = {lff_pkg::SYM_D0_0, fct_vc_i, lff_pkg::SYM_D0_0, lff_pkg::SYM_FCT};
         end
         SL_BC: begin
            case (bc_st_r)
               BC_IDLE: begin
                  w.k = 4'h1;
                  w.data = {bseq_mem_r[bc_i.chan], bc_i.btype, bc_i.chan,
                            lff_pkg::CW_BC_START, lff_pkg::SYM_COMMA};
               end
               BC_D1: begin
                  w.k = 4'h0;
                  w.data = bc_r.data[31:0];
               end
               BC_D2: begin
                  w.k = 4'h0;
                  w.data = bc_r.data[63:32];
               end
               default: begin
                  w.k = 4'h1;
                  w.data = {8'h00, bc_seq_r, lff_pkg::SYM_D0_0, lff_pkg::SYM_EBF};
               end
            endcase
         end
         SL_DF: begin
            case (df_st_r)
               DF_IDLE: begin
                  w.k = 4'h1;
                  w.data = {lff_pkg::SYM_D0_0, df_vc_i, lff_pkg::CW_DF_START,
                            lff_pkg::SYM_COMMA};
               end
               DF_BODY: begin
                  for (int i = 0; i < 4; i++) begin
                     if (i < int'(df_word_i.nchar)) begin
                        w.k[i] = df_word_i.chars[i].is_k;
                        w.data[8*i +: 8] = df_word_i.chars[i].val;
                     end else begin
                        w.k[i] = 1'b1;
                        w.data[8*i +: 8] = lff_pkg::SYM_NULL;
                     end
                  end
               end
               default: begin
                  w.k = 4'h1;
                  w.data = {16'h0000, df_seq_r, lff_pkg::SYM_EDF};
               end
            endcase
         end
         SL_IF: begin
            if (!if_act_r) begin
               w.k = 4'h1;
               w.data = {lff_pkg::SYM_D0_0, fseq_r, lff_pkg::CW_IF_START, lff_pkg::SYM_COMMA};
            end else if (if_cnt_r == 7'h00) begin
               w.k = 4'h0;
               w.data = seed_state;
            end else begin
               w.k = 4'h0;
               w.data = prbs_next;
            end
         end
         default: w = lff_pkg::lff_ctrl_word(lff_pkg::CW_IDLE, lff_pkg::SYM_D0_0);
      endcase
      word_data = w.data;
      // Checksum bytes go into the end words after the checksum has absorbed them.
      if (slot == SL_DF && df_st_r == DF_END) begin
         w.data[31:16] = crc16_out;
      end
      if (slot == SL_BC && bc_st_r == BC_END) begin
         w.data[31:24] = crc8_out;
      end
      tx_nxt = w;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output word and grant pulses.

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tx_o <= lff_pkg::lff_ctrl_word(lff_pkg::CW_IDLE, lff_pkg::SYM_D0_0);
      end else begin
         tx_o <= tx_nxt;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ctrl_grant_o <= '0;
         df_start_o <= 1'b0;
         df_pop_o <= 1'b0;
         bc_take_o <= 1'b0;
      end else begin
         ctrl_grant_o <= '{skip: slot == SL_SKIP, init: slot == SL_INIT,
                           init_acknowledge_word: slot == SL_INIT_ACKNOWLEDGE_WORD, reset_clear_word: slot == SL_RESET_CLEAR_WORD,
                           reset_acknowledge_word: slot == SL_RESET_ACKNOWLEDGE_WORD, los: slot == SL_LOS,
                           stby: slot == SL_STBY, lane_sync_word: slot == SL_LANE_SYNC_WORD,
                           ack: slot == SL_ACK, nack: slot == SL_NACK,
                           flow_control_token: slot == SL_FCT};
         df_start_o <= slot == SL_DF && df_st_r == DF_IDLE;
         df_pop_o <= slot == SL_DF && df_st_r == DF_BODY;
         bc_take_o <= slot == SL_BC && bc_st_r == BC_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequence counter.

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         fseq_r <= lff_pkg::FSEQ_RESET;
      end else if ((slot == SL_DF && df_st_r == DF_IDLE) ||
                   (slot == SL_BC && bc_st_r == BC_IDLE) ||
                   (slot == SL_IF && !if_act_r)) begin
         fseq_r <= fseq_r + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data frame.

   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !link_up_i) begin
         df_st_r <= DF_IDLE;
         df_cnt_r <= 7'h00;
         df_len_r <= 7'h01;
         df_vc_r <= 8'h00;
         df_seq_r <= 8'h00;
         df_crc_r <= lff_pkg::CRC16_INIT;
      end else if (slot == SL_DF) begin
         df_crc_r <= crc16_out;
         case (df_st_r)
            DF_IDLE: begin
               df_st_r <= DF_BODY;
               df_cnt_r <= 7'h00;
               df_len_r <= df_len_eff;
               df_vc_r <= df_vc_i;
               df_seq_r <= fseq_r;
            end
            DF_BODY: begin
               df_cnt_r <= df_cnt_r + 7'h01;
               if (df_cnt_r + 7'h01 == df_len_r) begin
                  df_st_r <= DF_END;
               end
            end
            DF_END: df_st_r <= DF_IDLE;
            default: df_st_r <= DF_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Broadcast frame and per-channel sequence.

   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !link_up_i) begin
         bc_st_r <= BC_IDLE;
         bc_r <= '0;
         bc_seq_r <= 8'h00;
         bc_crc_r <= lff_pkg::CRC8_INIT;
      end else if (slot == SL_BC) begin
         bc_crc_r <= crc8_out;
         case (bc_st_r)
            BC_IDLE: begin
               bc_st_r <= BC_D1;
               bc_r <= bc_i;
               bc_seq_r <= fseq_r;
            end
            BC_D1: bc_st_r <= BC_D2;
            BC_D2: bc_st_r <= BC_END;
            BC_END: bc_st_r <= BC_IDLE;
            default: bc_st_r <= BC_IDLE;
         endcase
      end
   end

   // The counters keep counting across link drops; only reset clears them.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         for (int i = 0; i < 256; i++) begin
            bseq_mem_r[i] <= lff_pkg::BSEQ_RESET;
         end
      end else if (slot == SL_BC && bc_st_r == BC_IDLE) begin
         bseq_mem_r[bc_i.chan] <= bseq_mem_r[bc_i.chan] + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle frame.

   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !link_up_i) begin
         if_act_r <= 1'b0;
         if_cnt_r <= 7'h00;
      end else if (slot == SL_BC || slot == SL_FCT || slot == SL_DF) begin
         if_act_r <= 1'b0;
         if_cnt_r <= 7'h00;
      end else if (slot == SL_IF) begin
         if (!if_act_r) begin
            if_act_r <= 1'b1;
            if_cnt_r <= 7'h00;
         end else if (if_cnt_r + 7'h01 == lff_pkg::IF_MAX_WORDS) begin
            if_act_r <= 1'b0;
            if_cnt_r <= 7'h00;
         end else begin
            if_cnt_r <= if_cnt_r + 7'h01;
         end
      end
   end

endmodule

`default_nettype wire

// ==== src/lff_pkg.sv ====
package lff_pkg;

   // Special symbols.
   localparam logic [7:0] SYM_COMMA = 8'hBC;
   localparam logic [7:0] SYM_EDF = 8'h7C;
   localparam logic [7:0] SYM_EBF = 8'h3C;
   localparam logic [7:0] SYM_FCT = 8'hDC;
   localparam logic [7:0] SYM_EOP = 8'h5C;
   localparam logic [7:0] SYM_EEP = 8'h1C;
   localparam logic [7:0] SYM_NULL = 8'hF7;
   localparam logic [7:0] SYM_RECEIVE_ERROR_WORD = 8'h00;
   localparam logic [7:0] SYM_D0_0 = 8'h00;

   // Second byte of each control word.
   localparam logic [7:0] CW_LANE_SYNC = 8'h43;
   localparam logic [7:0] CW_ACK = 8'hA3;
   localparam logic [7:0] CW_NACK = 8'hC3;
   localparam logic [7:0] CW_DF_START = 8'h45;
   localparam logic [7:0] CW_BC_START = 8'hA5;
   localparam logic [7:0] CW_IF_START = 8'hC6;
   localparam logic [7:0] CW_SKIP = 8'h26;
   localparam logic [7:0] CW_IDLE = 8'h46;
   localparam logic [7:0] CW_INIT = 8'hA6;
   localparam logic [7:0] CW_INIT_ACK = 8'hE6;
   localparam logic [7:0] CW_RESET_CLR = 8'h29;
   localparam logic [7:0] CW_RESET_ACK = 8'h49;
   localparam logic [7:0] CW_STANDBY = 8'hA9;
   localparam logic [7:0] CW_LOST_SIG = 8'hC9;

   // Frame limits and field layout.
   localparam logic [6:0] DF_MAX_WORDS = 7'h40;
   localparam logic [6:0] IF_MAX_WORDS = 7'h40;
   localparam int BSEQ_LSB = 29;
   localparam int BTYPE_LSB = 24;

   // Checksums and pseudo-random generator.
   localparam logic [15:0] CRC16_POLY = 16'h1021;
   localparam logic [15:0] CRC16_INIT = 16'h0000;
   localparam logic [7:0] CRC8_POLY = 8'h07;
   localparam logic [7:0] CRC8_INIT = 8'h00;
   localparam logic [31:0] PRBS_TAPS = 32'h80200003;
   localparam logic [31:0] SEED_RESET = 32'h00000001;
   localparam logic [31:0] PRBS_RESET = 32'h00000001;
   localparam logic [7:0] FSEQ_RESET = 8'h00;
   localparam logic [2:0] BSEQ_RESET = 3'h0;

   typedef struct packed {
      logic is_k;
      logic [7:0] val;
   } lff_char_t;

   typedef struct packed {
      logic [2:0] nchar;
      lff_char_t [3:0] chars;
   } lff_vcb_word_t;

   typedef struct packed {
      logic [7:0] chan;
      logic [4:0] btype;
      logic [63:0] data;
   } lff_bcast_t;

   typedef struct packed {
      logic [3:0] k;
      logic [31:0] data;
   } lff_lane_word_t;

   typedef struct packed {
      logic skip;
      logic init;
      logic init_acknowledge_word;
      logic reset_clear_word;
      logic reset_acknowledge_word;
      logic los;
      logic stby;
      logic lane_sync_word;
      logic ack;
      logic nack;
      logic flow_control_token;
   } lff_ctrl_req_t;

   function automatic lff_lane_word_t lff_ctrl_word(input logic [7:0] code,
                                                    input logic [7:0] arg);
      lff_lane_word_t w;
      w.k = 4'h1;
      w.data = {SYM_D0_0, arg, code, SYM_COMMA};
      return w;
   endfunction

endpackage

// ==== src/lff_crc.sv ====
`timescale 1ns/100ps
`default_nettype none

// Byte-serial checksum over one lane word, low byte first, msb of each byte first.
module lff_crc #(
   parameter int W = 16,
   parameter logic [W-1:0] POLY = '0
) (
   input wire logic [W-1:0] crc_i,
   input wire logic [31:0] data_i,
   input wire logic [2:0] nbytes_i,
   output logic [W-1:0] crc_o
);

   always_comb begin
      logic [W-1:0] c;
      logic fb;
      c = crc_i;
      fb = 1'b0;
      for (int b = 0; b < 4; b++) begin
         if (b < int'(nbytes_i)) begin
            for (int i = 7; i >= 0; i--) begin
               fb = c[W-1] ^ data_i[8*b+i];
               c = {c[W-2:0], 1'b0} ^ (fb ? POLY : '0);
            end
         end
      end
      crc_o = c;
   end

endmodule

`default_nettype wire

// ==== src/lff_lfsr.sv ====
`timescale 1ns/100ps
`default_nettype none

// Galois generator advanced by a whole 32-bit word per step.
module lff_lfsr #(
   parameter logic [31:0] TAPS = 32'h00000001,
   parameter logic [31:0] RESET_VAL = 32'h00000001
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic [31:0] seed_i,
   input wire logic step_i,
   output logic [31:0] state_o,
   output logic [31:0] next_o
);

   logic [31:0] state_r;

   always_comb begin
      logic [31:0] s;
      s = state_r;
      for (int i = 0; i < 32; i++) begin
         s = s[0] ? ((s >> 1) ^ TAPS) : (s >> 1);
      end
      next_o = s;
   end

   // An all-zero seed would lock the generator, so it is replaced by the reset value.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_r <= RESET_VAL;
      end else if (load_i) begin
         state_r <= (seed_i == 32'h00000000) ? RESET_VAL : seed_i;
      end else if (step_i) begin
         state_r <= next_o;
      end
   end

   assign state_o = state_r;

endmodule

`default_nettype wire

// ==== tb/lff_formatter_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module lff_formatter_chk (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic link_up_i,
   input wire logic retry_active_i,
   input wire lff_pkg::lff_ctrl_req_t ctrl_req_i,
   input wire lff_pkg::lff_lane_word_t tx_o,
   input wire lff_pkg::lff_ctrl_req_t ctrl_grant_o,
   input wire logic df_start_o,
   input wire logic bc_take_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   sdf_head_a: assert property (df_start_o |-> tx_o.k == 4'h1 && tx_o.data[15:0] == 16'h45BC)
      else $error("data start word malformed");
   sdf_top_a: assert property (df_start_o |-> tx_o.data[31:24] == 8'h00)
      else $error("data start top byte not zero");
   sbf_head_a: assert property (bc_take_o |-> tx_o.k == 4'h1 && tx_o.data[15:0] == 16'hA5BC)
      else $error("broadcast start word malformed");
   fct_word_a: assert property (ctrl_grant_o.flow_control_token |-> tx_o.k == 4'h1 && tx_o.data[7:0] == 8'hDC)
      else $error("flow token symbol wrong");
   link_down_a: assert property (!link_up_i |=> !df_start_o && !bc_take_o
      && !ctrl_grant_o.ack && !ctrl_grant_o.flow_control_token && !ctrl_grant_o.los) else $error("word sent while down");
   retry_hold_a: assert property (retry_active_i |=> !df_start_o && !bc_take_o && !ctrl_grant_o.flow_control_token)
      else $error("new traffic during resend");
   skip_wins_a: assert property (ctrl_req_i.skip && !ctrl_grant_o.skip |=> ctrl_grant_o.skip
      && tx_o.data[15:8] == 8'h26) else $error("skip not sent next");
   reset_clear_word_first_a: assert property (ctrl_req_i.reset_clear_word && ctrl_req_i.los && !ctrl_grant_o.reset_clear_word
      |=> !ctrl_grant_o.los) else $error("lost signal beat reset clear");
   one_word_a: assert property ($onehot0({ctrl_grant_o, df_start_o, bc_take_o}))
      else $error("two words in one cycle");
   cover property (df_start_o);
   cover property (bc_take_o);
   cover property (ctrl_grant_o.skip);
endmodule
bind lff_formatter lff_formatter_chk u_lff_formatter_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
   .link_up_i(link_up_i), .retry_active_i(retry_active_i), .ctrl_req_i(ctrl_req_i), .tx_o(tx_o),
   .ctrl_grant_o(ctrl_grant_o), .df_start_o(df_start_o), .bc_take_o(bc_take_o));
`default_nettype wire

// ==== tb/lff_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Far-end receiver that counts words per frame; it cannot recover from a broadcast frame cut by link loss.
module lff_peer (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire lff_pkg::lff_lane_word_t tx_i,
   output logic err_o
);
   logic ctl;
   logic in_df_r;
   logic in_bf_r;
   logic [7:0] df_cnt_r;
   logic [2:0] bf_cnt_r;
   assign ctl = tx_i.k[0] && tx_i.data[7:0] == 8'hBC;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         in_df_r <= 1'b0;
         in_bf_r <= 1'b0;
         err_o <= 1'b0;
      end else if (ctl && tx_i.data[15:8] == 8'h45) begin
         in_df_r <= 1'b1;
         df_cnt_r <= 8'h00;
      end else if (ctl && tx_i.data[15:8] == 8'hA5) begin
         in_bf_r <= 1'b1;
         bf_cnt_r <= 3'h0;
      end else if (tx_i.k[0] && tx_i.data[7:0] == 8'h7C) begin
         in_df_r <= 1'b0;
         err_o <= err_o | df_cnt_r < 8'h01 | df_cnt_r > 8'h40;
      end else if (tx_i.k[0] && tx_i.data[7:0] == 8'h3C) begin
         in_bf_r <= 1'b0;
         err_o <= err_o | bf_cnt_r != 3'h2;
      end else if (!ctl && in_bf_r) begin
         bf_cnt_r <= bf_cnt_r + 3'h1;
      end else if (!ctl && in_df_r) begin
         df_cnt_r <= df_cnt_r + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ==== tb/lff_formatter_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module lff_formatter_tb;
   logic clk_sys_i, reset_i, link_up_i, retry_active_i, df_req_i, bc_req_i;
   logic df_start_o, df_pop_o, bc_take_o, peer_err;
   logic [7:0] ack_seq_i, fct_vc_i, df_vc_i;
   logic [6:0] df_len_i;
   logic [12:0] ev;
   lff_pkg::lff_ctrl_req_t ctrl_req_i, ctrl_grant_o;
   lff_pkg::lff_vcb_word_t df_word_i;
   lff_pkg::lff_bcast_t bc_i;
   lff_pkg::lff_lane_word_t tx_o;
   int err_count = 0;
   int checked = 0;
   assign ev = {ctrl_grant_o, df_start_o, bc_take_o};
   lff_formatter u_lff_formatter (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link_up_i(link_up_i),
      .retry_active_i(retry_active_i), .ctrl_req_i(ctrl_req_i), .ack_seq_i(ack_seq_i),
      .fct_vc_i(fct_vc_i), .df_req_i(df_req_i), .df_vc_i(df_vc_i), .df_len_i(df_len_i),
      .df_word_i(df_word_i), .bc_req_i(bc_req_i), .bc_i(bc_i), .tx_o(tx_o),
      .ctrl_grant_o(ctrl_grant_o), .df_start_o(df_start_o), .df_pop_o(df_pop_o), .bc_take_o(bc_take_o));
   lff_peer u_lff_peer (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tx_i(tx_o), .err_o(peer_err));
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Sampling 1 ns after the edge keeps every check clear of the register update.
   task automatic tick;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wait_hi(input int sel);
      for (int i = 0; i < 200; i++) begin
         tick();
         if (ev[sel] === 1'b1) return;
      end
      chk("wait", 36'h1, 36'h0);
      print_verdict();
   endtask
   function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [31:0] w, input int n);
      for (int b = 0; b < n; b++) begin
         c = c ^ {w[8*b +: 8], 8'h00};
         for (int k = 0; k < 8; k++) begin
            c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction
   function automatic logic [7:0] crc_b(input logic [7:0] c, input logic [31:0] w, input int n);
      for (int b = 0; b < n; b++) begin
         c = c ^ w[8*b +: 8];
         for (int k = 0; k < 8; k++) begin
            c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_data;
      logic [15:0] c;
      @(negedge clk_sys_i);
      {link_up_i, retry_active_i, df_req_i} = 3'b111;
      repeat (6) tick();
      @(negedge clk_sys_i);
      retry_active_i = 1'b0;
      wait_hi(1);
      chk("sdf", {4'h1, 32'h005A45BC}, tx_o);
      c = crc_w(16'h0000, tx_o.data, 4);
      @(negedge clk_sys_i);
      df_req_i = 1'b0;
      tick();
      chk("w1", {4'h0, 32'h44332211}, tx_o);
      chk("pop", 36'h1, {35'h0, df_pop_o});
      c = crc_w(c, tx_o.data, 4);
      @(negedge clk_sys_i);
      df_word_i = {3'h3, 9'h000, 9'h15C, 9'h066, 9'h055};
      tick();
      chk("w2", {4'hC, 32'hF75C6655}, tx_o);
      c = crc_w(crc_w(c, tx_o.data, 4), 32'h0000007C, 2);
      tick();
      chk("edf", {4'h1, c, 16'h007C}, tx_o);
      $display("data test done");
   endtask
   task automatic t_bc(input logic [2:0] bs, input logic [7:0] sq);
      logic [7:0] c;
      @(negedge clk_sys_i);
      bc_req_i = 1'b1;
      wait_hi(0);
      chk("sbf", {4'h1, bs, 5'h0A, 8'h07, 16'hA5BC}, tx_o);
      @(negedge clk_sys_i);
      bc_req_i = 1'b0;
      tick();
      chk("d1", {4'h0, 32'h44332211}, tx_o);
      tick();
      chk("d2", {4'h0, 32'h88776655}, tx_o);
      tick();
      c = crc_b(crc_b(8'h00, {bs, 5'h0A, 8'h07, 16'hA5BC}, 4), 32'h44332211, 4);
      c = crc_b(crc_b(c, 32'h88776655, 4), {8'h00, sq, 16'h003C}, 3);
      chk("ebf", {4'h1, c, sq, 16'h003C}, tx_o);
      $display("broadcast test done");
   endtask
   task automatic t_idle;
      for (int i = 0; i < 20 && tx_o.data[15:0] !== 16'hC6BC; i++) tick();
      chk("sif", {4'h1, 32'h0003C6BC}, tx_o);
      repeat (65) tick();
      chk("sif2", {4'h1, 32'h0004C6BC}, tx_o);
      $display("idle test done");
   endtask
   task automatic t_ctrl(input logic [10:0] req, input logic [43:0] g, input logic [95:0] w);
      @(negedge clk_sys_i);
      ctrl_req_i = req;
      for (int i = 3; i >= 0; i--) begin
         if (i == 3) wait_hi(2 + $clog2(g[33 +: 11]));
         else tick();
         chk("grant", {25'h0, g[11*i +: 11]}, {25'h0, ctrl_grant_o});
         chk("ctrl", {12'h100, w[24*i +: 24]}, {tx_o.k, tx_o.data});
         @(negedge clk_sys_i);
         ctrl_req_i = ctrl_req_i & ~g[11*i +: 11];
      end
      $display("control test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset_i, link_up_i, retry_active_i, df_req_i, bc_req_i} = 5'b10000;
      {ack_seq_i, fct_vc_i, df_vc_i, df_len_i} = {8'h3E, 8'h21, 8'h5A, 7'h02};
      ctrl_req_i = '0;
      df_word_i = {3'h4, 9'h044, 9'h033, 9'h022, 9'h011};
      bc_i = {8'h07, 5'h0A, 64'h8877665544332211};
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      reset_i = 1'b0;
      t_data();
      t_bc(3'h0, 8'h01);
      t_bc(3'h1, 8'h02);
      t_idle();
      t_ctrl(11'h0A5, {11'h080, 11'h020, 11'h004, 11'h001}, {24'h0029BC, 24'h00C9BC,
         24'h3EA3BC, 24'h2100DC});
      t_ctrl(11'h41A, {11'h400, 11'h010, 11'h008, 11'h002}, {24'h0026BC, 24'h00A9BC,
         24'h0043BC, 24'h3EC3BC});
      link_up_i = 1'b0;
      {df_req_i, bc_req_i} = 2'b11;
      t_ctrl(11'h680, {11'h400, 11'h200, 11'h080, 11'h000}, {24'h0026BC, 24'h00A6BC,
         24'h0029BC, 24'h0046BC});
      t_ctrl(11'h140, {11'h100, 11'h040, 11'h000, 11'h000}, {24'h00E6BC, 24'h0049BC,
         24'h0046BC, 24'h0046BC});
      chk("peer", 36'h0, {35'h0, peer_err});
      print_verdict();
   end
endmodule
`default_nettype wire
